// ---- rtl/arp_pkg.sv ----
package arp_pkg;

  // Result word
  localparam int RESULT_W = 18;
  localparam logic [4:0] LAST_BIT = 5'h11;
  localparam logic [4:0] CNT_RST = 5'h00;
  localparam logic [17:0] RESULT_RST = 18'h00000;

  // Positions of the shared pins in the result word
  localparam int BIT_ELEVEN = 11;
  localparam int BIT_TWELVE = 12;
  localparam int BIT_THIRTEEN = 13;
  localparam int UPPER_LSB = 14;
  localparam int UPPER_W = 4;

  // Interface mode field value that selects the serial port
  localparam logic [1:0] MODE_SERIAL = 2'h3;

  // Master serial clock timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCLK_HALF_NS = 80;
  localparam int SCLK_HALF_CYCLES =
    (SCLK_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 : SCLK_HALF_NS / CLK_PERIOD_NS;

  // Positions in the synchronised pin vector
  localparam int SY_MODE_LSB = 0;
  localparam int SY_SRC = 2;
  localparam int SY_INV = 3;
  localparam int SY_POL = 4;
  localparam int SY_CS_N = 5;
  localparam int SY_RD_N = 6;
  localparam int SY_CNV_N = 7;
  localparam int SY_SCLK = 8;
  localparam int SY_W = 9;
  // Idle pin levels: strobes high, everything else low
  localparam logic [8:0] SY_RST = 9'h0e0;

  // Master serial clock sequencer
  typedef enum logic [2:0] {
    ARP_IDLE = 3'b001,
    ARP_LOW = 3'b010,
    ARP_HIGH = 3'b100
  } arp_mst_state_type;

endpackage

// ---- rtl/arp_sync.sv ----
`timescale 1ns/1ns
module arp_sync
  import arp_pkg::*;
#(
  parameter int WIDTH = SY_W,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Pins
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // Two stage synchroniser, first stage read only by the second
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// ---- rtl/arp_tick_gen.sv ----
`timescale 1ns/1ns
module arp_tick_gen
  import arp_pkg::*;
#(
  parameter int HALF = SCLK_HALF_CYCLES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Control
  input wire logic run_i,
  output logic tick_o
);

  localparam int CW = $clog2(HALF + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic [CW-1:0] cnt_q;

  // Divider restarts whenever the sequencer is idle
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end
    else if (cnt_q == LAST)
    begin
      cnt_q <= '0;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + CW'(1);
      tick_o <= 1'b0;
    end
  end

endmodule

// ---- rtl/arp_port.sv ----
`timescale 1ns/1ns
module arp_port
  import arp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Mode and strap pins
  input wire logic [1:0] mode_i,
  input wire logic clock_source_select_i,
  input wire logic clock_invert_select_i,
  input wire logic frame_polarity_select_i,
  // Host strobes
  input wire logic chip_select_n_i,
  input wire logic read_enable_n_i,
  input wire logic conversion_start_n_i,
  // Converter core
  input wire logic conv_done_i,
  input wire logic [RESULT_W-1:0] conv_result_i,
  output logic conv_start_o,
  output logic busy_o,
  // Bit 11 or serial clock
  input wire logic result_bit_eleven_i,
  output logic result_bit_eleven_o,
  output logic result_bit_eleven_oe_o,
  // Bit 12 or frame sync
  output logic result_bit_twelve_o,
  output logic result_bit_twelve_oe_o,
  // Bit 13 or incomplete read flag
  output logic result_bit_thirteen_o,
  output logic result_bit_thirteen_oe_o,
  // Bits 14 to 17
  output logic [UPPER_W-1:0] result_upper_o,
  output logic result_upper_oe_o,
  // Serial data
  output logic serial_result_out_o,
  output logic serial_result_out_oe_o
);

  logic [SY_W-1:0] pins_s;
  logic [1:0] mode_s;
  logic src_s;
  logic inv_s;
  logic pol_s;
  logic cs_n_s;
  logic rd_n_s;
  logic cnv_n_s;
  logic sclk_s;
  logic cnv_prev_q;
  logic sclk_prev_q;
  logic busy_q;
  logic pend_q;
  logic frame_q;
  logic mst_sclk_q;
  logic [1:0] mst_fall_q;
  logic tick;
  logic [RESULT_W-1:0] result_q;
  logic [RESULT_W-1:0] shift_q;
  logic [4:0] bit_cnt_q;
  arp_mst_state_type st_q;
  logic serial;
  logic master;
  logic slave;
  logic bus_en;
  logic cnv_fall;
  logic slave_edge;
  logic load;
  logic slave_shift;
  logic mst_start;
  logic mst_shift;
  logic incomplete;

  // Every pin from outside passes two flip-flops
  arp_sync #(
    .WIDTH(SY_W),
    .RST_VAL(SY_RST)
  ) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i({result_bit_eleven_i, conversion_start_n_i, read_enable_n_i,
              chip_select_n_i, frame_polarity_select_i,
              clock_invert_select_i, clock_source_select_i, mode_i}),
    .sync_o(pins_s)
  );

  // Unpack the synchronised pins
  assign mode_s = pins_s[SY_MODE_LSB+1:SY_MODE_LSB];
  assign src_s = pins_s[SY_SRC];
  assign inv_s = pins_s[SY_INV];
  assign pol_s = pins_s[SY_POL];
  assign cs_n_s = pins_s[SY_CS_N];
  assign rd_n_s = pins_s[SY_RD_N];
  assign cnv_n_s = pins_s[SY_CNV_N];
  assign sclk_s = pins_s[SY_SCLK];

  // Master clock half-period enable
  arp_tick_gen #(
    .HALF(SCLK_HALF_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .run_i(st_q != ARP_IDLE),
    .tick_o(tick)
  );

  // Mode decode and event terms
  always_comb
  begin
    serial = (mode_s == MODE_SERIAL);
    master = serial & ~src_s;
    slave = serial & src_s;
    bus_en = ~cs_n_s & ~rd_n_s;
    cnv_fall = cnv_prev_q & ~cnv_n_s;
    // Chip select gates the external clock
    slave_edge = ~cs_n_s & (inv_s ? (sclk_prev_q & ~sclk_s)
                                  : (~sclk_prev_q & sclk_s));
    load = conv_done_i & busy_q;
    // Edges beyond the last bit do not move the output
    slave_shift = slave & slave_edge & (bit_cnt_q != LAST_BIT) & ~load;
    mst_start = master & pend_q & bus_en & (st_q == ARP_IDLE) & ~load;
    // Master data moves a cycle after the clock pin has returned to its idle level
    mst_shift = master & mst_fall_q[1]
                & (bit_cnt_q != LAST_BIT) & ~load;
    // A slave read left half done when the next result lands
    incomplete = load & slave & (bit_cnt_q != CNT_RST)
                 & (bit_cnt_q != LAST_BIT);
  end

  // Edge history of start strobe and external clock
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnv_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      cnv_prev_q <= cnv_n_s;
      sclk_prev_q <= sclk_s;
    end
  end

  // Busy and conversion start
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      busy_q <= 1'b0;
      conv_start_o <= 1'b0;
    end
    else
    begin
      conv_start_o <= cnv_fall & ~busy_q;
      if (cnv_fall && !busy_q)
        busy_q <= 1'b1;
      else if (load)
        busy_q <= 1'b0;
    end
  end

  assign busy_o = busy_q;

  // Result latch and output shift register
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      result_q <= RESULT_RST;
      shift_q <= RESULT_RST;
      serial_result_out_o <= 1'b0;
      bit_cnt_q <= CNT_RST;
    end
    else if (load)
    begin
      result_q <= conv_result_i;
      shift_q <= conv_result_i;
      serial_result_out_o <= conv_result_i[RESULT_W-1];
      bit_cnt_q <= CNT_RST;
    end
    else if (slave_shift || mst_shift)
    begin
      shift_q <= {shift_q[RESULT_W-2:0], 1'b0};
      serial_result_out_o <= shift_q[RESULT_W-2];
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // Delay from the falling clock tick past the registered pin edge
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      mst_fall_q <= 2'h0;
    else if (load)
      mst_fall_q <= 2'h0;
    else
      mst_fall_q <= {mst_fall_q[0],
                     master & (st_q == ARP_HIGH) & tick};
  end

  // A fresh result waits for the master frame
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pend_q <= 1'b0;
    else if (load)
      pend_q <= 1'b1;
    else if (mst_start)
      pend_q <= 1'b0;
  end

  // Master clock sequencer, data moves only after a falling edge
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_q <= ARP_IDLE;
      mst_sclk_q <= 1'b0;
      frame_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        ARP_IDLE:
        begin
          if (mst_start)
          begin
            st_q <= ARP_LOW;
            frame_q <= 1'b1;
          end
        end
        ARP_LOW:
        begin
          if (!master || load)
          begin
            st_q <= ARP_IDLE;
            frame_q <= 1'b0;
          end
          else if (tick)
          begin
            st_q <= ARP_HIGH;
            mst_sclk_q <= 1'b1;
          end
        end
        ARP_HIGH:
        begin
          if (!master || load)
          begin
            st_q <= ARP_IDLE;
            mst_sclk_q <= 1'b0;
            frame_q <= 1'b0;
          end
          else if (tick)
          begin
            mst_sclk_q <= 1'b0;
            if (bit_cnt_q == LAST_BIT)
            begin
              st_q <= ARP_IDLE;
              frame_q <= 1'b0;
            end
            else
              st_q <= ARP_LOW;
          end
        end
        default:
        begin
          st_q <= ARP_IDLE;
          mst_sclk_q <= 1'b0;
          frame_q <= 1'b0;
        end
      endcase
    end
  end

  // Shared pin drivers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      result_bit_eleven_o <= 1'b0;
      result_bit_twelve_o <= 1'b0;
      result_bit_thirteen_o <= 1'b0;
      result_upper_o <= '0;
      result_bit_eleven_oe_o <= 1'b0;
      result_bit_twelve_oe_o <= 1'b0;
      result_bit_thirteen_oe_o <= 1'b0;
      result_upper_oe_o <= 1'b0;
      serial_result_out_oe_o <= 1'b0;
    end
    else
    begin
      result_bit_eleven_o <= serial ? (mst_sclk_q ^ inv_s)
                                    : result_q[BIT_ELEVEN];
      result_bit_twelve_o <= serial ? (frame_q ^ pol_s)
                                    : result_q[BIT_TWELVE];
      result_bit_thirteen_o <= serial ? incomplete
                                      : result_q[BIT_THIRTEEN];
      result_upper_o <= result_q[RESULT_W-1:UPPER_LSB];
      result_bit_eleven_oe_o <= bus_en & ~slave;
      result_bit_twelve_oe_o <= bus_en;
      result_bit_thirteen_oe_o <= bus_en;
      result_upper_oe_o <= bus_en;
      serial_result_out_oe_o <= bus_en & serial;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_conv_begin;
    cnv_fall && !busy_q;
  endsequence

  sequence s_latched;
    !busy_o && shift_q == $past(conv_result_i);
  endsequence

  property p_busy_rise;
    s_conv_begin |=> busy_o && conv_start_o;
  endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy did not rise on conversion start");

  property p_busy_fall;
    load |=> s_latched;
  endproperty
  a_busy_fall: assert property (p_busy_fall)
    else $error("busy fell without the result in the shift register");

  property p_msb_first;
    load |=> serial_result_out_o == $past(conv_result_i[RESULT_W-1]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("serial data did not start with the top bit");

  property p_slave_rise;
    slave && !inv_s && slave_shift |=>
      serial_result_out_o == $past(shift_q[RESULT_W-2]);
  endproperty
  a_slave_rise: assert property (p_slave_rise)
    else $error("slave data not updated on rising clock");

  property p_slave_fall;
    slave && inv_s && !sclk_s && sclk_prev_q && !cs_n_s && !load
      && bit_cnt_q != LAST_BIT |=> bit_cnt_q == $past(bit_cnt_q) + 5'h01;
  endproperty
  a_slave_fall: assert property (p_slave_fall)
    else $error("slave data not updated on falling clock");

  property p_cnt_cap;
    bit_cnt_q == LAST_BIT && !load |=> bit_cnt_q == LAST_BIT;
  endproperty
  a_cnt_cap: assert property (p_cnt_cap)
    else $error("serial output moved past the last bit");

  property p_mst_hold;
    master && st_q == ARP_HIGH && !load |=> $stable(serial_result_out_o);
  endproperty
  a_mst_hold: assert property (p_mst_hold)
    else $error("master data changed while the clock was high");

  property p_sync_high;
    master && frame_q && !pol_s && $stable(pol_s) |=> result_bit_twelve_o;
  endproperty
  a_sync_high: assert property (p_sync_high)
    else $error("frame sync not high during frame");

  property p_sync_low;
    master && frame_q && pol_s && $stable(pol_s) |=> !result_bit_twelve_o;
  endproperty
  a_sync_low: assert property (p_sync_low)
    else $error("frame sync not low during frame");

  property p_incomplete;
    incomplete |=> result_bit_thirteen_o ##1 !result_bit_thirteen_o;
  endproperty
  a_incomplete: assert property (p_incomplete)
    else $error("incomplete read flag did not pulse");

  property p_parallel;
    !serial && bus_en |=> result_bit_eleven_oe_o
      && result_bit_thirteen_o == $past(result_q[BIT_THIRTEEN]);
  endproperty
  a_parallel: assert property (p_parallel)
    else $error("parallel bits not driven");

  property p_float;
    !bus_en |=> !result_upper_oe_o && !result_bit_eleven_oe_o
      && !serial_result_out_oe_o;
  endproperty
  a_float: assert property (p_float)
    else $error("pins driven while output bus disabled");

endmodule

// ---- dv/arp_host.sv ----
`timescale 1ns/1ns
module arp_host (
  // Serial pins
  input wire logic sd_i,
  output logic sclk_o
);
  // Clock stands still outside reads
  initial sclk_o = 1'b0;

  // Park the clock at its idle level while the bus is off
  task automatic park(input logic inv);
    sclk_o = inv;
  endtask

  // Read with a given count of active edges, 160 ns half period
  task automatic read(input logic inv, input int edges,
    output logic [17:0] w, output logic last);
    #160;
    w = {17'h00000, sd_i};
    last = sd_i;
    for (int k = 1; k <= edges; k++)
    begin
      sclk_o = ~inv;
      #160;
      sclk_o = inv;
      if (k < 18)
        w = {w[16:0], sd_i};
      last = sd_i;
      #160;
    end
  endtask
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import arp_pkg::*;
  // Design inputs
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [1:0] mode = 2'h0;
  logic src = 1'b0, inv = 1'b0, pol = 1'b0;
  logic cs_n = 1'b1, rd_n = 1'b1, cnv_n = 1'b1, done = 1'b0;
  logic [17:0] result = 18'h00000;
  // Design outputs and pin levels
  logic cstart, busy, b11_o, b11_oe, b12_o, b12_oe, b13_o, b13_oe;
  logic sd_o, sd_oe, upper_oe, host_sclk, sclk_pin, sd_pin;
  logic [3:0] upper;
  logic tog = 1'b0;
  // Bench state
  int bad_count = 0, tests_run = 0;
  logic [31:0] seed = 32'ha83d4daa;
  logic [17:0] word, got;
  logic last, err_seen;

  // Clock, and a released data line that never holds its last value
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) tog <= ~tog;
  assign sclk_pin = b11_oe ? b11_o : host_sclk;
  assign sd_pin = sd_oe ? sd_o : tog;

  arp_port i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .mode_i(mode),
    .clock_source_select_i(src), .clock_invert_select_i(inv),
    .frame_polarity_select_i(pol), .chip_select_n_i(cs_n),
    .read_enable_n_i(rd_n), .conversion_start_n_i(cnv_n),
    .conv_done_i(done), .conv_result_i(result), .conv_start_o(cstart),
    .busy_o(busy), .result_bit_eleven_i(sclk_pin),
    .result_bit_eleven_o(b11_o), .result_bit_eleven_oe_o(b11_oe),
    .result_bit_twelve_o(b12_o), .result_bit_twelve_oe_o(b12_oe),
    .result_bit_thirteen_o(b13_o), .result_bit_thirteen_oe_o(b13_oe),
    .result_upper_o(upper), .result_upper_oe_o(upper_oe),
    .serial_result_out_o(sd_o), .serial_result_out_oe_o(sd_oe));
  arp_host i_host (.sd_i(sd_pin), .sclk_o(host_sclk));

  // Expected parallel pins: bits 17..14, then 13..11
  function automatic logic [6:0] par_exp(input logic [17:0] w);
    return {w[17:14], w[13:11]};
  endfunction

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic rnd(output logic [17:0] w);
    seed = xs(seed);
    w = seed[17:0];
  endtask

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Inputs move 2 ns after the rising edge
  task automatic tick();
    @(posedge clk_i);
    #2;
  endtask

  task automatic bus(input logic en, input int n);
    cs_n = ~en;
    rd_n = ~en;
    repeat (n) tick();
  endtask

  // One conversion; records whether the bit-13 pin pulsed at the latch
  task automatic convert(input logic [17:0] w);
    int t;
    t = 0;
    tick();
    cnv_n = 1'b0;
    while (busy !== 1'b1 && t < 10)
    begin
      tick();
      t++;
    end
    check(18'(t), 18'h00003);
    check({17'h0, cstart}, 18'h00001);
    repeat (3) tick();
    cnv_n = 1'b1;
    tick();
    check({17'h0, busy}, 18'h00001);
    done = 1'b1;
    result = w;
    tick();
    done = 1'b0;
    err_seen = 1'b0;
    check({17'h0, busy}, 18'h00000);
    repeat (4)
    begin
      err_seen |= b13_o & b13_oe;
      tick();
    end
  endtask

  // Capture a master frame on the serial clock edges that leave its idle level
  task automatic master_read(input logic [17:0] exp);
    logic [17:0] w;
    int n, t;
    logic prev, s;
    w = 18'h00000;
    n = 0;
    t = 0;
    prev = 1'b0;
    while (b12_o !== ~pol && t < 20)
    begin
      tick();
      t++;
    end
    while (n < 18 && t < 400)
    begin
      tick();
      t++;
      s = sclk_pin ^ inv;
      if (s && !prev)
      begin
        w = {w[16:0], sd_pin};
        n++;
        check({17'h0, b12_o}, {17'h0, ~pol});
      end
      if (!s && prev)
        check({17'h0, sd_pin}, {17'h0, w[0]});
      prev = s;
    end
    check(w, exp);
    check(18'(n), 18'h00012);
    repeat (6) tick();
    check({17'h0, b12_o}, {17'h0, pol});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    #1000000;
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_i);
    #2 rstn_i = 1'b1;
    check({15'h0, busy, b11_oe, b13_oe}, 18'h00000);
    // Parallel modes, a corner word first
    for (int m = 0; m < 3; m++)
      for (int j = 0; j < 3; j++)
      begin
        mode = 2'(m);
        bus(1'b1, 4);
        if (j == 0)
          word = 18'h2aaaa ^ {18{m[0]}};
        else
          rnd(word);
        convert(word);
        repeat (2) tick();
        check({11'h0, upper, b13_o, b12_o, b11_o},
          {11'h0, par_exp(word)});
        check({14'h0, upper_oe, b11_oe, b12_oe, b13_oe},
          18'h0000f);
      end
    bus(1'b0, 4);
    check({15'h0, b11_oe, b12_oe, b13_oe}, 18'h00000);
    // Slave serial, both clock senses, with extra edges on the second read
    mode = MODE_SERIAL;
    src = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      inv = i[0];
      i_host.park(inv);
      bus(1'b1, 4);
      for (int j = 0; j < 2; j++)
      begin
        rnd(word);
        if (j == 0)
          word = 18'h30001;
        convert(word);
        check({13'h0, upper_oe, upper},
          {13'h0, 1'b1, word[17:14]});
        check({16'h0, b11_oe, b13_oe}, 18'h00001);
        i_host.read(inv, 17 + 3 * j, got, last);
        check(got, word);
        check({17'h0, last}, {17'h0, word[0]});
      end
      bus(1'b0, 4);
    end
    // Unfinished read overtaken by a new result
    bus(1'b1, 4);
    rnd(word);
    convert(word);
    i_host.read(inv, 5, got, last);
    rnd(word);
    convert(word);
    check({17'h0, err_seen}, 18'h00001);
    i_host.read(inv, 17, got, last);
    check(got, word);
    rnd(word);
    convert(word);
    check({17'h0, err_seen}, 18'h00000);
    // Master serial, both frame polarities
    for (int p = 0; p < 2; p++)
    begin
      bus(1'b0, 1);
      src = 1'b0;
      pol = p[0];
      inv = p[0];
      repeat (4) tick();
      rnd(word);
      convert(word);
      bus(1'b1, 0);
      master_read(word);
    end
    final_report();
  end
endmodule
